// File: tsc_control_status.sv
/*
  main control and status register bank of a three-input touch sensor:
  gain and power controls, attention flag and pin, touch, light-done,
  noise and saturating delta registers.
  assumes: sensing front end and light engines on ref_clk; their
  strobes are one-cycle pulses; register port on ref_clk.
*/
`timescale 1ns/1ps
`include "tsc_consts.svh"

// Overview of operation
// - gain field bits 7:6 select gain 1, 2, 4 or 8.
// - the same gain is applied in standby and active states.
// - with standby bit set, only standby-selected inputs are scanned.
// - on standby, dropped inputs report one release then stay untouched.
// - in standby status holds until attention clear; host-driven lights act normally.
// - deep sleep stops scanning, idles lights, no pulse-width activity.
// - entering deep sleep clears all status and attention flag.
// - attention flag set drives attention output.
// - touch on input with interrupt disabled never raises attention.
// - host writes zero to clear attention; ended conditions then clear.
// - light done summary is OR of light behaviour done bits.
// - simultaneous press block shows blocking, never raises attention.
// - pattern flag raises attention only if enabled; holds while cause stays.
// - general touch bit is OR of pad touched flags.
// - touched flag clears on attention clear with touch ended, or when its input leaves the scan set.
// - light done sets on host-actuated finish, ignored if linked, clears on attention clear.
// - noise flag forces that input's delta count to zero.
// - noise flags do not latch, follow the front end directly.
// - noisy input counts as over pattern threshold, only once.
// - low-frequency and radio noise samples discarded unless filter off.
// - each delta is two's complement, refreshed once per sensing cycle.
// - delta saturates at 7Fh and 80h instead of wrapping.
// - standby scan set comes from register at 40h.
// - undefined addresses read 00h and ignore writes.
module tsc_control_status #(
  parameter int NUM_INPUTS = 3,
  parameter int RAW_WIDTH = 12
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // sensing front end, same clock
  input wire logic [NUM_INPUTS-1:0] sample_valid,
  input wire logic [NUM_INPUTS*RAW_WIDTH-1:0] sample_delta,
  input wire logic [NUM_INPUTS-1:0] touch_detect,
  input wire logic [NUM_INPUTS-1:0] lowfreq_noise,
  input wire logic [NUM_INPUTS-1:0] radio_noise,
  input wire logic [NUM_INPUTS-1:0] pattern_over,
  input wire logic pattern_enable,
  input wire logic pattern_exceeded,
  input wire logic multi_block,
  // light engines
  input wire logic [NUM_INPUTS-1:0] light_done_pulse,
  input wire logic [NUM_INPUTS-1:0] light_linked,
  // controls toward sensing and lights
  output logic [1:0] gain_select,
  output logic [3:0] gain_factor,
  output logic [NUM_INPUTS-1:0] scan_enable,
  output logic lights_idle,
  output logic pwm_enable,
  output logic [NUM_INPUTS-1:0] pattern_count_over,
  output logic [NUM_INPUTS-1:0] sample_discard,
  // attention pin, open drain: enable high pulls low
  output logic attention_n_out,
  output logic attention_n_oe
);

  // host-visible control registers
  logic [7:0] main_control;
  logic [7:0] standby_channel;
  logic [7:0] filter_ctrl;
  logic [7:0] irq_enable;
  // status flags and saturated counts
  logic attention_pending;
  logic [NUM_INPUTS-1:0] pad_touched_flags;
  logic [NUM_INPUTS-1:0] light_behaviour_done;
  logic [NUM_INPUTS-1:0] pad_noise_flags;
  logic pattern_threshold_flag;
  logic [7:0] delta_count [NUM_INPUTS];
  // edge history and derived one-cycle events
  logic deep_prev;
  logic [NUM_INPUTS-1:0] scan_prev;
  logic [NUM_INPUTS-1:0] touch_live;
  logic [NUM_INPUTS-1:0] release_seen;
  logic [NUM_INPUTS-1:0] touch_rise;
  logic pattern_rise;
  logic pattern_prev;
  logic [NUM_INPUTS-1:0] touch_prev;
  logic deep_entry;
  logic attention_clear;
  // decoded power state and read mux
  tsc_pkg::tsc_power_t power_state;
  logic [7:0] next_rdata;

  // field views of the control registers and status summaries
  wire mc_write = reg_write && (reg_addr == `TSC_ADDR_MAIN_CONTROL);
  wire lowfreq_filter_off = filter_ctrl[`TSC_FC_LOWFREQ_OFF];
  wire radio_filter_off = filter_ctrl[`TSC_FC_RADIO_OFF];
  wire pattern_irq_enable = irq_enable[`TSC_IE_PATTERN];
  wire light_done_summary = |light_behaviour_done;
  wire general_touch = |pad_touched_flags;

  // power state from the two sleep bits; deep sleep wins
  // both bits set means deep sleep, so software need not
  // clear standby before going to the lowest state
  always_comb begin
    if (main_control[`TSC_MC_DEEP_SLEEP]) begin
      power_state = tsc_pkg::TSC_PWR_DEEP;
    end else if (main_control[`TSC_MC_STANDBY]) begin
      power_state = tsc_pkg::TSC_PWR_STANDBY;
    end else begin
      power_state = tsc_pkg::TSC_PWR_ACTIVE;
    end
  end

  // gain is not gated by power state, so standby uses it unchanged
  // factor is a plain decode for the front end; no extra register,
  // so a new code takes effect the cycle after the write
  always_comb begin
    gain_select = main_control[`TSC_MC_GAIN_HI:`TSC_MC_GAIN_LO];
    case (tsc_pkg::tsc_gain_t'(gain_select))
      tsc_pkg::TSC_GAIN_X1: gain_factor = 4'h1;
      tsc_pkg::TSC_GAIN_X2: gain_factor = 4'h2;
      tsc_pkg::TSC_GAIN_X4: gain_factor = 4'h4;
      tsc_pkg::TSC_GAIN_X8: gain_factor = 4'h8;
      default: gain_factor = 4'h1;
    endcase
  end

  // scan set and light engine gating per power state
  // standby keeps lights running: linked and host-driven alike
  // only the lower bits of the standby set matter here
  always_comb begin
    case (power_state)
      tsc_pkg::TSC_PWR_ACTIVE: begin
        scan_enable = '1;
        lights_idle = 1'b0;
        pwm_enable = 1'b1;
      end
      tsc_pkg::TSC_PWR_STANDBY: begin
        scan_enable = standby_channel[NUM_INPUTS-1:0];
        lights_idle = 1'b0;
        pwm_enable = 1'b1;
      end
      tsc_pkg::TSC_PWR_DEEP: begin
        scan_enable = '0;
        lights_idle = 1'b1;
        pwm_enable = 1'b0;
      end
      default: begin
        scan_enable = '0;
        lights_idle = 1'b1;
        pwm_enable = 1'b0;
      end
    endcase
  end

  // noise on an input counts toward the pattern once, merged by OR
  // discard follows the raw noise levels, not the registered flags,
  // so the very sample that carries noise is dropped
  always_comb begin
    pattern_count_over = pattern_enable ? (pattern_over | pad_noise_flags) : '0;
    sample_discard = (lowfreq_noise & {NUM_INPUTS{~lowfreq_filter_off}}) |
                     (radio_noise & {NUM_INPUTS{~radio_filter_off}});
  end

  // live touch: scanned, not noisy; a dropped input reads released
  // a rising live touch is the only touch event that may raise attention,
  // so a held touch never re-arms it after a host clear
  always_comb begin
    touch_live = touch_detect & scan_enable & ~pad_noise_flags & ~sample_discard;
    touch_rise = touch_live & ~touch_prev;
    pattern_rise = pattern_exceeded & ~pattern_prev;
    deep_entry = main_control[`TSC_MC_DEEP_SLEEP] & ~deep_prev;
    attention_clear = mc_write & ~reg_wdata[`TSC_MC_ATTENTION]
                      & attention_pending;
  end

  // edge history of touches, pattern, sleep and scan set
  // reset values match the idle levels, so no false edge after reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      touch_prev <= '0;
      pattern_prev <= 1'b0;
      deep_prev <= 1'b0;
      scan_prev <= '1;
    end else begin
      touch_prev <= touch_live;
      pattern_prev <= pattern_exceeded;
      deep_prev <= main_control[`TSC_MC_DEEP_SLEEP];
      scan_prev <= scan_enable;
    end
  end

  // one release report for each input dropped from the scan set
  // one-cycle pulse, a cycle late; flags of dropped inputs clear then
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      release_seen <= '0;
    end else begin
      release_seen <= scan_prev & ~scan_enable;
    end
  end

  // host-written controls; attention bit and unused control, filter and enable bits ignore a write of one; standby set keeps all eight bits
  // status, noise and delta addresses fall to the default branch,
  // so a stray write can never disturb a stored flag or count
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      main_control <= `TSC_RST_MAIN_CONTROL;
      standby_channel <= `TSC_RST_STANDBY_CHANNEL;
      filter_ctrl <= `TSC_RST_FILTER_CTRL;
      irq_enable <= `TSC_RST_IRQ_ENABLE;
    end else if (reg_write) begin
      case (reg_addr)
        `TSC_ADDR_MAIN_CONTROL: main_control <= {reg_wdata[7:4], 4'h0};
        `TSC_ADDR_STANDBY_CHANNEL: standby_channel <= reg_wdata;
        `TSC_ADDR_FILTER_CTRL: filter_ctrl <= {6'h00, reg_wdata[1:0]};
        `TSC_ADDR_IRQ_ENABLE: irq_enable <= {4'h0, reg_wdata[3:0]};
        default: ;
      endcase
    end
  end

  // attention flag: enabled touch and pattern events and any light finish set it, set wins over host clear
  // losing an event to a racing clear would hide it from the host,
  // a spare interrupt is the cheaper fault
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      attention_pending <= 1'b0;
    end else if (deep_entry) begin
      attention_pending <= 1'b0;
    end else if (|(touch_rise & irq_enable[NUM_INPUTS-1:0]) || (|light_done_pulse)
                 || (pattern_rise && pattern_irq_enable)) begin
      attention_pending <= 1'b1;
    end else if (attention_clear) begin
      attention_pending <= 1'b0;
    end
  end

  // touched flags latch; clear on attention clear only once touch ended
  // a touch still held keeps its flag but raises no new attention
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pad_touched_flags <= '0;
    end else if (deep_entry) begin
      pad_touched_flags <= '0;
    end else begin
      for (int i = 0; i < NUM_INPUTS; i++) begin
        if (touch_live[i]) begin
          pad_touched_flags[i] <= 1'b1;
        end else if (attention_clear || release_seen[i]) begin
          pad_touched_flags[i] <= 1'b0;
        end
      end
    end
  end

  // light done: host-actuated only; pulse beats the clear
  // linked lights finish often and would only flood the status
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      light_behaviour_done <= '0;
    end else if (deep_entry) begin
      light_behaviour_done <= '0;
    end else begin
      light_behaviour_done <= (light_behaviour_done & ~{NUM_INPUTS{attention_clear}})
                              | (light_done_pulse & ~light_linked);
    end
  end

  // pattern flag stays while its cause is present
  // clears on a host clear once the front end drops the condition
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pattern_threshold_flag <= 1'b0;
    end else if (deep_entry) begin
      pattern_threshold_flag <= 1'b0;
    end else if (pattern_exceeded) begin
      pattern_threshold_flag <= 1'b1;
    end else if (attention_clear) begin
      pattern_threshold_flag <= 1'b0;
    end
  end

  // noise flags track the front end; not sticky
  // unscanned inputs report no noise, their samples are stale anyway
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pad_noise_flags <= '0;
    end else begin
      pad_noise_flags <= (lowfreq_noise | radio_noise) & scan_enable;
    end
  end

  // delta counts: saturate wide raw value into signed 8 bits
  // clamping beats wrapping: a wrapped count would flip its sign
  // and turn a strong touch into a release
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_INPUTS; i++) begin
        delta_count[i] <= `TSC_RST_ZERO;
      end
    end else begin
      for (int i = 0; i < NUM_INPUTS; i++) begin
        if (deep_entry) begin
          delta_count[i] <= `TSC_RST_ZERO;
        end else if (pad_noise_flags[i] || (sample_valid[i] && sample_discard[i])) begin
          delta_count[i] <= `TSC_RST_ZERO;
        end else if (sample_valid[i]) begin
          if ($signed(sample_delta[i*RAW_WIDTH +: RAW_WIDTH]) > $signed(12'sh07F)) begin
            delta_count[i] <= `TSC_DELTA_MAX;
          end else if ($signed(sample_delta[i*RAW_WIDTH +: RAW_WIDTH]) < $signed(-12'sh080)) begin
            delta_count[i] <= `TSC_DELTA_MIN;
          end else begin
            delta_count[i] <= sample_delta[i*RAW_WIDTH +: 8];
          end
        end
      end
    end
  end

  // read decode; unmapped answers zero
  // reads have no side effects, latched status clears only on attention clear, deep sleep entry or scan drop
  always_comb begin
    next_rdata = 8'h00;
    case (reg_addr)
      `TSC_ADDR_MAIN_CONTROL: next_rdata = {main_control[7:4], 3'h0, attention_pending};
      `TSC_ADDR_GENERAL_STATUS: next_rdata = {3'h0, light_done_summary, 1'b0,
                                              multi_block, pattern_threshold_flag,
                                              general_touch};
      `TSC_ADDR_INPUT_TOUCH: next_rdata = {5'h00, pad_touched_flags};
      `TSC_ADDR_LIGHT_DONE: next_rdata = {5'h00, light_behaviour_done};
      `TSC_ADDR_NOISE_FLAGS: next_rdata = {5'h00, pad_noise_flags};
      `TSC_ADDR_DELTA1: next_rdata = delta_count[0];
      `TSC_ADDR_DELTA2: next_rdata = delta_count[1];
      `TSC_ADDR_DELTA3: next_rdata = delta_count[2];
      `TSC_ADDR_STANDBY_CHANNEL: next_rdata = standby_channel;
      `TSC_ADDR_FILTER_CTRL: next_rdata = filter_ctrl;
      `TSC_ADDR_IRQ_ENABLE: next_rdata = irq_enable;
      default: next_rdata = 8'h00;
    endcase
  end

  // read data stand only in the cycle after the strobe
  // zero between reads keeps stale data off the bus
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_read ? next_rdata : 8'h00;
    end
  end

  // attention pin pulled low while flag is set
  // open drain: the board pull-up gives the released level
  always_comb begin
    attention_n_out = 1'b0;
    attention_n_oe = attention_pending;
  end

endmodule // tsc_control_status

// File: tsc_consts.svh
/*
  register offsets, field positions, reset values and limits of the
  touch sensor control and status bank.
  assumes: included by bare name from the design file.
*/
`ifndef TSC_CONSTS_SVH
`define TSC_CONSTS_SVH

`define TSC_ADDR_MAIN_CONTROL 8'h00
`define TSC_ADDR_GENERAL_STATUS 8'h02
`define TSC_ADDR_INPUT_TOUCH 8'h03
`define TSC_ADDR_LIGHT_DONE 8'h04
`define TSC_ADDR_NOISE_FLAGS 8'h0A
`define TSC_ADDR_DELTA1 8'h10
`define TSC_ADDR_DELTA2 8'h11
`define TSC_ADDR_DELTA3 8'h12
`define TSC_ADDR_STANDBY_CHANNEL 8'h40
`define TSC_ADDR_FILTER_CTRL 8'hE0
`define TSC_ADDR_IRQ_ENABLE 8'hE1

`define TSC_MC_GAIN_HI 7
`define TSC_MC_GAIN_LO 6
`define TSC_MC_STANDBY 5
`define TSC_MC_DEEP_SLEEP 4
`define TSC_MC_ATTENTION 0

`define TSC_GS_LIGHT_DONE 4
`define TSC_GS_MULTI_BLOCK 2
`define TSC_GS_PATTERN 1
`define TSC_GS_TOUCH 0

`define TSC_FC_LOWFREQ_OFF 0
`define TSC_FC_RADIO_OFF 1
`define TSC_IE_PATTERN 3

`define TSC_RST_MAIN_CONTROL 8'h00
`define TSC_RST_STANDBY_CHANNEL 8'h00
`define TSC_RST_FILTER_CTRL 8'h00
`define TSC_RST_IRQ_ENABLE 8'h07
`define TSC_RST_ZERO 8'h00

`define TSC_DELTA_MAX 8'h7F
`define TSC_DELTA_MIN 8'h80

`endif

// File: tsc_pkg.sv
/*
  types shared by the touch sensor control and status bank.
  assumes: nothing beyond the constants header.
*/
package tsc_pkg;
  // sensing gain multiplier selected by the gain field
  typedef enum logic [1:0] {
    TSC_GAIN_X1 = 2'h0,
    TSC_GAIN_X2 = 2'h1,
    TSC_GAIN_X4 = 2'h2,
    TSC_GAIN_X8 = 2'h3
  } tsc_gain_t;

  // power state, one-hot
  typedef enum logic [2:0] {
    TSC_PWR_ACTIVE = 3'h1,
    TSC_PWR_STANDBY = 3'h2,
    TSC_PWR_DEEP = 3'h4
  } tsc_power_t;
endpackage

// File: tsc_control_status_sva.sv
/*
  port-level checker for the touch sensor control and status bank.
  assumes: bound onto tsc_control_status; single ref_clk domain, nrst async low.
*/
`timescale 1ns/1ps
module tsc_control_status_sva #(
  parameter int NUM_INPUTS = 3,
  parameter int RAW_WIDTH = 12
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // sensing and light events
  input wire logic [NUM_INPUTS-1:0] touch_detect,
  input wire logic [NUM_INPUTS-1:0] pattern_over,
  input wire logic pattern_enable,
  input wire logic pattern_exceeded,
  input wire logic multi_block,
  input wire logic [NUM_INPUTS-1:0] light_done_pulse,
  // controls and pin
  input wire logic [1:0] gain_select,
  input wire logic [3:0] gain_factor,
  input wire logic [NUM_INPUTS-1:0] scan_enable,
  input wire logic lights_idle,
  input wire logic pwm_enable,
  input wire logic [NUM_INPUTS-1:0] pattern_count_over,
  input wire logic attention_n_out,
  input wire logic attention_n_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // no event that could raise attention in this cycle
  logic quiet;
  assign quiet = !(|touch_detect) && !(|light_done_pulse) && !pattern_exceeded;

  AST_GAIN_DECODE: assert property (gain_factor == (4'h1 << gain_select))
    else $error("gain factor does not match gain code");
  AST_GAIN_WRITE: assert property (
    reg_write && reg_addr == 8'h00 |=> {gain_select, 6'h00} == ($past(reg_wdata) & 8'hC0))
    else $error("gain code not taken from control write");
  AST_STANDBY_OFF: assert property (
    reg_write && reg_addr == 8'h00 && reg_wdata[5:4] == 2'b00 |=> scan_enable == '1)
    else $error("active state does not scan every input");
  AST_DEEP_STOP: assert property (lights_idle |-> scan_enable == '0 && !pwm_enable)
    else $error("deep sleep still scans or pulses");
  AST_DEEP_CLEAR: assert property ($rose(lights_idle) |-> ##[0:1] !attention_n_oe)
    else $error("attention kept on deep sleep entry");
  AST_PIN_DRIVE: assert property (attention_n_oe |-> attention_n_out == 1'b0)
    else $error("attention pin enabled but not low");
  AST_ATTN_CLEAR: assert property (
    reg_write && reg_addr == 8'h00 && !reg_wdata[0] && quiet |=> !attention_n_oe)
    else $error("attention not released by host clear");
  AST_MULTI_QUIET: assert property (
    multi_block && quiet && !attention_n_oe |=> !attention_n_oe)
    else $error("multiple touch blocking raised attention");
  AST_PATTERN_COUNT: assert property (
    pattern_enable |-> (pattern_count_over & pattern_over) == pattern_over)
    else $error("pattern count misses an input over threshold");
  AST_UNMAPPED_READ: assert property (
    reg_read && !(reg_addr inside {8'h00, 8'h02, 8'h03, 8'h04, 8'h0A, 8'h10, 8'h11, 8'h12,
                                   8'h40, 8'hE0, 8'hE1}) |=> reg_rdata == 8'h00)
    else $error("unmapped read returned data");

  // main scenarios reached
  COV_ATTN: cover property ($rose(attention_n_oe));
  COV_DEEP: cover property ($rose(lights_idle));
  COV_READ: cover property (reg_read ##1 reg_rdata != 8'h00);
endmodule // tsc_control_status_sva

bind tsc_control_status tsc_control_status_sva #(
  .NUM_INPUTS(NUM_INPUTS),
  .RAW_WIDTH(RAW_WIDTH)
) u_sva (.*);

// File: tsc_host_model.sv
/*
  host controller model: master of the bank's register port.
  assumes: shares ref_clk with the bank; callers issue one request at a time.
*/
`timescale 1ns/1ps
module tsc_host_model (
  // clock
  input wire logic ref_clk,
  // register port
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_write,
  output logic reg_read,
  input wire logic [7:0] reg_rdata
);
  // idle port at time zero
  initial begin
    reg_addr = 8'hFF;
    reg_wdata = 8'hFF;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end

  // one write cycle; address and data inverted once released, never left looking valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
  endtask

  // one read cycle; data only stands in the following cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask
endmodule // tsc_host_model

// File: tsc_control_status_tb_top.sv
/*
  self-checking bench for the touch sensor control and status bank.
  assumes: host model drives the register port; bench drives front end and lights.
*/
`timescale 1ns/1ps
module tsc_control_status_tb_top;
  logic ref_clk, nrst, reg_write, reg_read, pattern_enable, pattern_exceeded, multi_block;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [2:0] sample_valid, touch_detect, lowfreq_noise, radio_noise, pattern_over;
  logic [2:0] light_done_pulse, light_linked, scan_enable, pattern_count_over, sample_discard;
  logic [35:0] sample_delta;
  logic [1:0] gain_select;
  logic [3:0] gain_factor;
  logic lights_idle, pwm_enable, attention_n_out, attention_n_oe;
  logic [7:0] ra [11] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h0A, 8'h10, 8'h11, 8'h12,
                          8'h40, 8'hE1, 8'h55};
  int miscompares = 0;
  int n_checks = 0;

  tsc_control_status #(.NUM_INPUTS(3), .RAW_WIDTH(12)) u_dut (.*);
  tsc_host_model u_host (.*);

  // 50 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host.rd(a, d);
    chk(d, e);
  endtask

  task automatic ochk(input logic e);
    chk(8'(attention_n_oe), 8'(e));
  endtask

  task automatic end_sim;
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (100000) @(posedge ref_clk);
    miscompares++;
    end_sim();
  end

  // main sequence
  initial begin
    nrst = 1'b0;
    {sample_valid, sample_delta, touch_detect, lowfreq_noise, radio_noise, pattern_over,
     pattern_enable, pattern_exceeded, multi_block, light_done_pulse, light_linked} = '0;
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    u_host.wr(8'h55, 8'hFF);
    foreach (ra[i]) rchk(ra[i], ra[i] == 8'hE1 ? 8'h07 : 8'h00);
    // every gain code, active then standby
    for (int g = 0; g < 4; g++) begin
      u_host.wr(8'h00, {2'(g), 6'h00});
      chk(8'(gain_factor), 8'h01 << g);
      rchk(8'h00, {2'(g), 6'h00});
      u_host.wr(8'h00, {2'(g), 6'h20});
      chk(8'(gain_factor), 8'h01 << g);
    end
    u_host.wr(8'h40, 8'h05);
    chk(8'(scan_enable), 8'h05);
    rchk(8'h40, 8'h05);
    u_host.wr(8'h00, 8'h00);
    chk(8'(scan_enable), 8'h07);
    // touch held across a host clear
    @(posedge ref_clk);
    touch_detect <= 3'b001;
    rchk(8'h03, 8'h01);
    rchk(8'h02, 8'h01);
    ochk(1'b1);
    u_host.wr(8'h00, 8'h00);
    rchk(8'h03, 8'h01);
    ochk(1'b0);
    @(posedge ref_clk);
    touch_detect <= 3'b011;
    @(posedge ref_clk);
    touch_detect <= 3'b000;
    u_host.wr(8'h00, 8'h00);
    rchk(8'h03, 8'h00);
    rchk(8'h02, 8'h00);
    // blocking and pattern events
    @(posedge ref_clk);
    multi_block <= 1'b1;
    rchk(8'h02, 8'h04);
    ochk(1'b0);
    multi_block <= 1'b0;
    pattern_exceeded <= 1'b1;
    rchk(8'h02, 8'h02);
    ochk(1'b0);
    pattern_exceeded <= 1'b0;
    u_host.wr(8'hE1, 8'h0F);
    pattern_exceeded <= 1'b1;
    rchk(8'h02, 8'h02);
    ochk(1'b1);
    pattern_exceeded <= 1'b0;
    u_host.wr(8'h00, 8'h00);
    rchk(8'h02, 8'h00);
    // host-driven light finishes, linked one ignored
    @(posedge ref_clk);
    light_done_pulse <= 3'b010;
    light_linked <= 3'b100;
    @(posedge ref_clk);
    light_done_pulse <= 3'b100;
    @(posedge ref_clk);
    light_done_pulse <= 3'b000;
    rchk(8'h04, 8'h02);
    rchk(8'h02, 8'h10);
    u_host.wr(8'h00, 8'h00);
    rchk(8'h04, 8'h00);
    // saturating deltas and read-only writes
    @(posedge ref_clk);
    sample_delta <= {12'h012, 12'h800, 12'h7FF};
    sample_valid <= 3'b111;
    @(posedge ref_clk);
    sample_valid <= 3'b000;
    rchk(8'h10, 8'h7F);
    rchk(8'h11, 8'h80);
    rchk(8'h12, 8'h12);
    u_host.wr(8'h10, 8'h55);
    u_host.wr(8'h03, 8'hFF);
    rchk(8'h10, 8'h7F);
    rchk(8'h03, 8'h00);
    // noise on input one: zero delta, discards, pattern count
    @(posedge ref_clk);
    radio_noise <= 3'b001;
    lowfreq_noise <= 3'b001;
    pattern_enable <= 1'b1;
    pattern_over <= 3'b011;
    @(posedge ref_clk);
    sample_valid <= 3'b001;
    @(posedge ref_clk);
    sample_valid <= 3'b000;
    #1 chk(8'(pattern_count_over), 8'h03);
    chk(8'(sample_discard), 8'h01);
    rchk(8'h10, 8'h00);
    rchk(8'h0A, 8'h01);
    u_host.wr(8'hE0, 8'h03);
    chk(8'(sample_discard), 8'h00);
    radio_noise <= 3'b000;
    lowfreq_noise <= 3'b000;
    rchk(8'h0A, 8'h00);
    // standby drops input two while touched; input one stays scanned
    @(posedge ref_clk);
    touch_detect <= 3'b011;
    u_host.wr(8'h00, 8'h21);
    repeat (2) @(posedge ref_clk);
    rchk(8'h03, 8'h01);
    ochk(1'b1);
    touch_detect <= 3'b000;
    u_host.wr(8'h00, 8'h00);
    rchk(8'h03, 8'h00);
    // masked input, then deep sleep with attention pending
    u_host.wr(8'hE1, 8'h06);
    touch_detect <= 3'b001;
    repeat (3) @(posedge ref_clk);
    #1 ochk(1'b0);
    @(posedge ref_clk);
    touch_detect <= 3'b011;
    @(posedge ref_clk);
    touch_detect <= 3'b000;
    u_host.wr(8'h00, 8'h11);
    chk(8'(scan_enable), 8'h00);
    chk({6'h00, lights_idle, pwm_enable}, 8'h02);
    ochk(1'b1);
    @(posedge ref_clk);
    #1 ochk(1'b0);
    rchk(8'h03, 8'h00);
    rchk(8'h02, 8'h00);
    end_sim();
  end
endmodule // tsc_control_status_tb_top
